// ==== bench/rc_decoder_chk.sv ====
// Purpose: Port checks of the packet decoder
// Assumes: Pin synchronisers settle within six cycles
// Notes: Long sleep or a quiet line flushes the sync pipeline
`timescale 1ns/10ps

module rc_decoder_chk #(
	parameter int DATA_W = 8
) (
	input  wire logic              clock_i,
	input  wire logic              reset_n_i,
	input  wire logic              rx_data_i,
	input  wire logic              sleep_request_n_i,
	input  wire logic [DATA_W-1:0] decoded_outputs_o,
	input  wire logic              valid_transmission_o,
	input  wire logic              raw_data_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	// Steps that precede the checked moments
	sequence s_asleep;
		!sleep_request_n_i [*8];
	endsequence
	sequence s_quiet;
		!rx_data_i [*6];
	endsequence

	a_sleep_drops_out: assert property (s_asleep |-> !valid_transmission_o && decoded_outputs_o == '0)
		else $error("outputs active while asleep");
	a_sleep_mutes_raw: assert property (s_asleep |-> !raw_data_o)
		else $error("raw stream active while asleep");
	a_raw_follows_line: assert property ((sleep_request_n_i && $stable(rx_data_i)) [*8] |-> raw_data_o == rx_data_i)
		else $error("raw stream differs from line");
	a_sync_delay: assert property (s_quiet ##1 rx_data_i |=> !raw_data_o)
		else $error("line reached output unsynchronised");
	a_idle_outputs_low: assert property (!valid_transmission_o |-> decoded_outputs_o == '0)
		else $error("outputs high without valid flag");
	a_outputs_hold: assert property (valid_transmission_o && $past(valid_transmission_o) |-> $stable(decoded_outputs_o))
		else $error("outputs changed while valid");
	a_rise_after_gap: assert property ($rose(valid_transmission_o) |-> !raw_data_o)
		else $error("valid rose inside a frame");
	a_rise_needs_wake: assert property ($rose(valid_transmission_o) |-> $past(sleep_request_n_i, 8))
		else $error("valid rose soon after sleep");
endmodule : rc_decoder_chk

bind remote_control_packet_decoder rc_decoder_chk #(.DATA_W(DATA_W)) i_rc_decoder_chk (
	.clock_i              (clock_i),
	.reset_n_i            (reset_n_i),
	.rx_data_i            (rx_data_i),
	.sleep_request_n_i    (sleep_request_n_i),
	.decoded_outputs_o    (decoded_outputs_o),
	.valid_transmission_o (valid_transmission_o),
	.raw_data_o           (raw_data_o)
);

// ==== bench/rc_transmitter.sv ====
// Purpose: Remote transmitter model driving the demodulated line
// Assumes: Symbols are coded by high time within one bit period
// Notes: Line rests low between frames, which is also the frame gap
`timescale 1ns/10ps

module rc_transmitter #(
	parameter int BIT_CYC = 40
) (
	// Clock
	input  wire logic clock_i,
	// Serial line
	output logic      line_o
);
	initial line_o = 1'b0;

	// One frame: rise per bit, then a low gap longer than two periods
	task automatic send_frame(input rc_decoder_pkg::sym_t sym_a [18]);
		int hi;
		foreach (sym_a[i])
		begin
			hi = (sym_a[i] == rc_decoder_pkg::SYM_ONE) ? BIT_CYC * 3 / 4 :
				(sym_a[i] == rc_decoder_pkg::SYM_OPEN) ? BIT_CYC / 2 : BIT_CYC / 4;
			@(posedge clock_i);
			line_o <= 1'b1;
			repeat (hi) @(posedge clock_i);
			line_o <= 1'b0;
			repeat (BIT_CYC - hi - 1) @(posedge clock_i);
		end
		repeat (3 * BIT_CYC) @(posedge clock_i);
	endtask : send_frame
endmodule : rc_transmitter

// ==== bench/remote_control_packet_decoder_test.sv ====
// Purpose: Self-checking bench of the packet decoder
// Assumes: Short bit and hold counts keep the run brief
// Notes: Frames come from the transmitter model
`timescale 1ns/10ps
`include "rc_decoder_cfg.svh"

module remote_control_packet_decoder_test;
	localparam int BIT_CYC  = 40;
	localparam int HOLD_CYC = 2000;
	typedef rc_decoder_pkg::sym_t frame_t [18];

	logic        clock_i;
	logic        reset_n_i;
	logic        rx_data_i;
	logic        sleep_n;
	logic [9:0]  addr_pins;
	logic        dsel;
	logic [1:0]  acfg;
	logic [7:0]  dout;
	logic        vt;
	logic        raw;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	int          err_count;
	int          checks;

	remote_control_packet_decoder #(.BIT_CYC(BIT_CYC), .HOLD_CYC(HOLD_CYC)) i_remote_control_packet_decoder (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .rx_data_i(rx_data_i), .sleep_request_n_i(sleep_n),
		.local_addr_pins_i(addr_pins), .data_bit_type_sel_i(dsel), .addr_type_sel_hi_i(acfg[1]),
		.addr_type_sel_lo_i(acfg[0]), .decoded_outputs_o(dout), .valid_transmission_o(vt), .raw_data_o(raw),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_o(irq));
	rc_transmitter #(.BIT_CYC(BIT_CYC)) i_rc_transmitter (.clock_i(clock_i), .line_o(rx_data_i));

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_pins(input logic v, input logic [7:0] d);
		chk_word({23'h0, vt, dout}, {23'h0, v, d});
	endtask : chk_pins

	// Bus cycle held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		@(posedge clock_i);
		while (pready !== 1'b1)
			@(posedge clock_i);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, exp);
	endtask : rd_chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	function automatic frame_t make_frame(input logic [9:0] a, input logic [7:0] d);
		frame_t f;
		for (int i = 0; i < 10; i++)
			f[i] = a[i] ? ((acfg == 2'h2) ? rc_decoder_pkg::SYM_OPEN : rc_decoder_pkg::SYM_ONE) :
				((acfg == 2'h1) ? rc_decoder_pkg::SYM_OPEN : rc_decoder_pkg::SYM_ZERO);
		for (int i = 0; i < 8; i++)
			f[10 + i] = d[i] ? rc_decoder_pkg::SYM_ONE :
				(dsel ? rc_decoder_pkg::SYM_ZERO : rc_decoder_pkg::SYM_OPEN);
		return f;
	endfunction : make_frame

	// Flip puts a wrong address into the frame
	task automatic send(input logic [7:0] d, input int n, input logic [9:0] flip);
		repeat (n) i_rc_transmitter.send_frame(make_frame(addr_pins ^ flip, d));
	endtask : send

	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		chk_pins(1'b0, 8'h00);
		chk_word({31'h0, pready}, 32'h1);
		rd_chk(`REG_CTRL, 32'h1);
		rd_chk(`REG_IRQ_MASK, 32'h0);
		rd_chk(`REG_STATUS, 32'h400);
		apb(1'b0, 12'h014, 32'h0, r, e);
		chk_word(r, 32'h0);
		chk_word({31'h0, e}, 32'h1);
	endtask : t_reset

	task automatic t_irq;
		rd_chk(`REG_IRQ_STATUS, 32'h0);
		send(8'h5a, 2, 10'h0);
		chk_pins(1'b1, 8'h5a);
		rd_chk(`REG_STATUS, 32'h115a);
		rd_chk(`REG_LAST_DATA, 32'h5a);
		chk_word({31'h0, irq}, 32'h0);
		wr(`REG_IRQ_MASK, 32'h7);
		@(posedge clock_i);
		chk_word({31'h0, irq}, 32'h1);
		rd_chk(`REG_IRQ_STATUS, 32'h1);
		@(posedge clock_i);
		chk_word({31'h0, irq}, 32'h0);
		send(8'hc3, 1, 10'h0);
		chk_pins(1'b0, 8'h00);
		send(8'hc3, 1, 10'h0);
		chk_pins(1'b1, 8'hc3);
		send(8'hc3, 1, 10'h001);
		chk_pins(1'b0, 8'h00);
		rd_chk(`REG_IRQ_STATUS, 32'h7);
	endtask : t_irq

	task automatic t_modes;
		for (int i = 0; i < 4; i++)
		begin
			acfg <= i[1:0];
			dsel <= i[0];
			repeat (8) @(posedge clock_i);
			send(8'h96, 2, 10'h0);
			chk_pins(1'b1, 8'h96);
			repeat (HOLD_CYC + 100) @(posedge clock_i);
			chk_pins(1'b0, 8'h00);
		end
	endtask : t_modes

	task automatic t_sleep;
		sleep_n <= 1'b0;
		repeat (10) @(posedge clock_i);
		rd_chk(`REG_STATUS, 32'h2200);
		send(8'h3c, 2, 10'h0);
		chk_pins(1'b0, 8'h00);
		sleep_n <= 1'b1;
		repeat (8) @(posedge clock_i);
		wr(`REG_CTRL, 32'h0);
		rd_chk(`REG_STATUS, 32'h2000);
		wr(`REG_CTRL, 32'h1);
		repeat (4) @(posedge clock_i);
		rd_chk(`REG_STATUS, 32'h400);
		send(8'h3c, 2, 10'h0);
		chk_pins(1'b1, 8'h3c);
		repeat (HOLD_CYC + 100) @(posedge clock_i);
	endtask : t_sleep

	// All-equal addresses are never accepted
	task automatic t_bad_addr;
		logic [31:0] r;
		logic        e;
		apb(1'b0, `REG_IRQ_STATUS, 32'h0, r, e);
		for (int i = 0; i < 2; i++)
		begin
			addr_pins <= {10{i[0]}};
			repeat (8) @(posedge clock_i);
			send(8'h81, 2, 10'h0);
			chk_pins(1'b0, 8'h00);
			rd_chk(`REG_IRQ_STATUS, 32'h4);
		end
	endtask : t_bad_addr

	task automatic summarize;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// 100 MHz clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Main sequence
	initial
	begin
		reset_n_i = 1'b0;
		sleep_n = 1'b1;
		addr_pins = 10'h2a5;
		dsel = 1'b1;
		acfg = 2'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_count = 0;
		checks = 0;
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_irq;
		t_modes;
		t_sleep;
		t_bad_addr;
		summarize;
	end

	// Watchdog, about three times the expected run
	initial
	begin
		repeat (90000) @(posedge clock_i);
		err_count++;
		summarize;
	end
endmodule : remote_control_packet_decoder_test

// ==== common/rc_decoder_cfg.svh ====
// Purpose: Offsets, reset values and timing counts of the remote control packet decoder
// Assumes: clock_i at 100 MHz; APB register window of 4 KiB
// Notes: Times are kept in their own unit and turned into cycles here
// Summary of operation
// (R1) Decoded outputs copy transmitter data lines
// (R2) Valid flag high after accepted transmission
// (R3) Sleep request low stops all reception
// (R4) Raw received stream brought out undecoded
// (R5) Received address must equal local address pins
// (R6) Local address ten bits, all-same rejected
// (R7) Address inputs idle high when unconnected
// (R8) Data type select idles low, picks zero/open
// (R9) Address type selects idle low and high
// (R10) Two identical matched packets before output update
// (R11) Any mismatch drops outputs and flag low
// (R12) Data bits decode one/zero or one/open
// (R13) Strap pair picks address bit interpretation
// (R14) Pin inputs synchronised before any decision
`ifndef RC_DECODER_CFG_SVH
`define RC_DECODER_CFG_SVH

// Timing
`define CLK_FREQ_MHZ      100
`define BIT_PERIOD_US     400
`define BIT_PERIOD_CYC    (`BIT_PERIOD_US * `CLK_FREQ_MHZ)
`define HOLD_TIMEOUT_US   40000
`define HOLD_TIMEOUT_CYC  (`HOLD_TIMEOUT_US * `CLK_FREQ_MHZ)

// Packet layout
`define ADDR_BITS         10
`define DATA_BITS         8

// Pad pull levels seen when a strap or address pin is open
`define ADDR_PIN_RESET    10'h3ff
`define DATA_SEL_RESET    1'b0
`define ADDR_LO_RESET     1'b0
`define ADDR_HI_RESET     1'b1

// Register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_IRQ_STATUS    12'h008
`define REG_IRQ_MASK      12'h00c
`define REG_LAST_DATA     12'h010

// Register fields and reset values
`define CTRL_EN_BIT       0
`define CTRL_RESET        1'b1
`define IRQ_VALID_UP      0
`define IRQ_VALID_DOWN    1
`define IRQ_REJECT        2
`define IRQ_BITS          3
`define IRQ_MASK_RESET    3'h0

`endif

// ==== common/rc_decoder_pkg.sv ====
// Purpose: Types shared by the decoder modules
// Assumes: rc_decoder_cfg.svh supplies widths
// Notes: Symbol codes follow the three-level line convention
`include "rc_decoder_cfg.svh"

package rc_decoder_pkg;

	// Received bit symbol; code 2'h3 never produced
	typedef enum logic [1:0] {
		SYM_ZERO = 2'h0,
		SYM_ONE  = 2'h1,
		SYM_OPEN = 2'h2
	} sym_t;

	// Decoder states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_ARMED = 4'h2,
		ST_VALID = 4'h4,
		ST_SLEEP = 4'h8
	} dec_state_t;

	// Strap pins after synchronisation
	typedef struct packed {
		logic data_sel;
		logic addr_hi;
		logic addr_lo;
	} strap_t;

	// One sliced bit
	typedef struct packed {
		logic valid;
		sym_t sym;
	} sym_evt_t;

endpackage : rc_decoder_pkg

// ==== rtl/bit_slicer.sv ====
// Purpose: Turns the serial line into bit symbols by pulse width
// Assumes: Each bit starts with a rising edge; high share sets the symbol
// Notes: Short high is zero, long high is one, half high is open
`timescale 1ns/10ps
`include "rc_decoder_cfg.svh"

module bit_slicer #(
	parameter int BIT_CYC = `BIT_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     reset_n_i,
	// Line in
	input  wire logic                     enable_i,
	input  wire logic                     line_i,
	// Results
	output rc_decoder_pkg::sym_evt_t      evt_o,
	output logic                          timing_err_o,
	output logic                          gap_o
);

	localparam int CW = $clog2(2 * BIT_CYC + 2);
	localparam logic [CW-1:0] PER_MIN = CW'(BIT_CYC * 3 / 4);
	localparam logic [CW-1:0] PER_MAX = CW'(BIT_CYC * 5 / 4);
	localparam logic [CW-1:0] HI_LOW  = CW'(BIT_CYC * 3 / 8);
	localparam logic [CW-1:0] HI_HIGH = CW'(BIT_CYC * 5 / 8);
	localparam logic [CW-1:0] GAP_CYC = CW'(BIT_CYC * 2);

	logic          line_q;
	logic          in_bit_q;
	logic          tail_q;
	logic [CW-1:0] per_q;
	logic [CW-1:0] hi_q;
	rc_decoder_pkg::sym_t sym;

	// Classify by high time
	always_comb
	begin
		if (hi_q < HI_LOW)
			sym = rc_decoder_pkg::SYM_ZERO;
		else if (hi_q > HI_HIGH)
			sym = rc_decoder_pkg::SYM_ONE;
		else
			sym = rc_decoder_pkg::SYM_OPEN;
	end

	// Measure each bit; last bit of a frame closes on the gap
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			line_q       <= 1'b0;
			in_bit_q     <= 1'b0;
			tail_q       <= 1'b0;
			per_q        <= '0;
			hi_q         <= '0;
			evt_o        <= '0;
			timing_err_o <= 1'b0;
			gap_o        <= 1'b0;
		end
		else
		begin
			line_q       <= line_i & enable_i;
			evt_o.valid  <= 1'b0;
			timing_err_o <= 1'b0;
			// Gap trails the last symbol by one cycle so the frame store holds it first
			gap_o        <= tail_q;
			tail_q       <= 1'b0;
			if (!enable_i)
				in_bit_q <= 1'b0;
			else if (line_i && !line_q)
			begin
				if (in_bit_q)
				begin
					evt_o        <= '{valid: 1'b1, sym: sym};
					timing_err_o <= (per_q < PER_MIN) || (per_q > PER_MAX);
				end
				in_bit_q <= 1'b1;
				per_q    <= CW'(1);
				hi_q     <= CW'(1);
			end
			else if (in_bit_q)
			begin
				per_q <= per_q + CW'(1);
				if (line_i)
					hi_q <= hi_q + CW'(1);
				if (per_q == GAP_CYC)
				begin
					evt_o    <= '{valid: 1'b1, sym: sym};
					tail_q   <= 1'b1;
					in_bit_q <= 1'b0;
				end
			end
		end
	end

endmodule : bit_slicer

// ==== rtl/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clock_i
// Notes: RST gives the pad pull level so an open pin reads right at once
`timescale 1ns/10ps

module pin_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         reset_n_i,
	// Pins and clean levels
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once the later stages agree
	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge clock_i or negedge reset_n_i)
		begin
			if (!reset_n_i)
				level_o[i] <= RST[i];
			else if (s2_q[i] == s3_q[i])
				level_o[i] <= s3_q[i];
		end
	end

endmodule : pin_sync

// ==== rtl/remote_control_packet_decoder.sv ====
// Purpose: Receiver-side packet decoder with latched outputs and APB status
// Assumes: rx_data_i is the demodulated stream; strap and address pins are static
// Notes: Frame closes two bit periods after the last bit's rising edge; address first, A0 and D0 first
`timescale 1ns/10ps
`include "rc_decoder_cfg.svh"

module remote_control_packet_decoder #(
	parameter int ADDR_W   = `ADDR_BITS,
	parameter int DATA_W   = `DATA_BITS,
	parameter int BIT_CYC  = `BIT_PERIOD_CYC,
	parameter int HOLD_CYC = `HOLD_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              reset_n_i,
	// Radio side
	input  wire logic              rx_data_i,
	input  wire logic              sleep_request_n_i,
	// Straps and address
	input  wire logic [ADDR_W-1:0] local_addr_pins_i,
	input  wire logic              data_bit_type_sel_i,
	input  wire logic              addr_type_sel_hi_i,
	input  wire logic              addr_type_sel_lo_i,
	// Decoded outputs
	output logic      [DATA_W-1:0] decoded_outputs_o,
	output logic                   valid_transmission_o,
	output logic                   raw_data_o,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Interrupt
	output logic                   irq_o
);

	localparam int PKT = ADDR_W + DATA_W;
	localparam int NW  = $clog2(PKT + 2);
	localparam int TW  = $clog2(HOLD_CYC + 1);

	// Synchronised pins
	logic [ADDR_W-1:0] addr_s;
	logic              rx_s;
	logic              awake_s;
	rc_decoder_pkg::strap_t strap_s;

	// Slicer results
	rc_decoder_pkg::sym_evt_t evt;
	logic              timing_err;
	logic              gap;

	// Frame store
	rc_decoder_pkg::sym_t [PKT-1:0] rx_sym_q;
	logic [NW-1:0]     sym_cnt_q;
	logic              frame_bad_q;

	// Frame evaluation
	logic [ADDR_W-1:0] addr_hit;
	logic [DATA_W-1:0] data_ok;
	logic [DATA_W-1:0] data_val;
	logic              addr_legal;
	logic              pkt_good;

	// Decoder state
	rc_decoder_pkg::dec_state_t state_q;
	logic [DATA_W-1:0] stored_q;
	logic [TW-1:0]     hold_q;
	logic              hold_done;
	logic              run;

	// Registers
	logic              ctrl_en_q;
	logic [`IRQ_BITS-1:0] irq_stat_q;
	logic [`IRQ_BITS-1:0] irq_mask_q;
	logic [`IRQ_BITS-1:0] irq_evt;
	logic              ev_up;
	logic              ev_down;
	logic              ev_reject;
	logic              wr_en;
	logic              rd_en;
	logic              setup;
	logic [31:0]       rdata;
	logic              mapped;

	// Address pins idle high through their pad pull
	pin_sync #(
		.W   (ADDR_W),
		.RST (ADDR_W'(`ADDR_PIN_RESET))
	) u_addr_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.pin_i     (local_addr_pins_i),
		.level_o   (addr_s)
	); // (R7) (R14)

	// Straps: data select idles low, address pair idles low/high
	pin_sync #(
		.W   (3),
		.RST ({`DATA_SEL_RESET, `ADDR_HI_RESET, `ADDR_LO_RESET})
	) u_strap_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.pin_i     ({data_bit_type_sel_i, addr_type_sel_hi_i, addr_type_sel_lo_i}),
		.level_o   (strap_s)
	); // (R8) (R9) (R14)

	// Serial line and sleep request; sleep resets to awake
	pin_sync #(
		.W   (2),
		.RST (2'h2)
	) u_line_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.pin_i     ({sleep_request_n_i, rx_data_i}),
		.level_o   ({awake_s, rx_s})
	); // (R14)

	// Reception stops while asleep or disabled by software
	assign run = awake_s & ctrl_en_q; // (R3)

	bit_slicer #(
		.BIT_CYC (BIT_CYC)
	) u_slicer (
		.clock_i      (clock_i),
		.reset_n_i    (reset_n_i),
		.enable_i     (run),
		.line_i       (rx_s),
		.evt_o        (evt),
		.timing_err_o (timing_err),
		.gap_o        (gap)
	);

	// Raw stream mirrors the line regardless of address; silent in sleep
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			raw_data_o <= 1'b0;
		else
			raw_data_o <= rx_s & awake_s; // (R4) (R3)
	end

	// Collect symbols; overlong or badly timed frames are marked bad
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_sym_q    <= '0;
			sym_cnt_q   <= '0;
			frame_bad_q <= 1'b0;
		end
		else if (gap || !run)
		begin
			sym_cnt_q   <= '0;
			frame_bad_q <= 1'b0;
		end
		else
		begin
			if (timing_err)
				frame_bad_q <= 1'b1; // (R11)
			if (evt.valid)
			begin
				if (sym_cnt_q < NW'(PKT))
				begin
					rx_sym_q[sym_cnt_q] <= evt.sym;
					sym_cnt_q           <= sym_cnt_q + NW'(1);
				end
				else
					frame_bad_q <= 1'b1;
			end
		end
	end

	// Per address bit: expected symbol from local pin and strap pair
	for (genvar i = 0; i < ADDR_W; i++)
	begin : g_addr
		rc_decoder_pkg::sym_t exp_sym;
		always_comb
		begin
			exp_sym = rc_decoder_pkg::SYM_ONE;
			if (addr_s[i])
				exp_sym = (strap_s.addr_hi && !strap_s.addr_lo) ?
					rc_decoder_pkg::SYM_OPEN : rc_decoder_pkg::SYM_ONE; // (R13)
			else
				exp_sym = (!strap_s.addr_hi && strap_s.addr_lo) ?
					rc_decoder_pkg::SYM_OPEN : rc_decoder_pkg::SYM_ZERO; // (R13)
		end
		assign addr_hit[i] = (rx_sym_q[i] == exp_sym); // (R5)
	end

	// Per data bit: one is high; low symbol is zero or open by strap
	for (genvar j = 0; j < DATA_W; j++)
	begin : g_data
		rc_decoder_pkg::sym_t s;
		assign s           = rx_sym_q[ADDR_W + j];
		assign data_val[j] = (s == rc_decoder_pkg::SYM_ONE);
		assign data_ok[j]  = data_val[j] ||
			(strap_s.data_sel ? (s == rc_decoder_pkg::SYM_ZERO)
			                  : (s == rc_decoder_pkg::SYM_OPEN)); // (R12)
	end

	// All-high and all-low local addresses are not usable pairings
	assign addr_legal = (addr_s != '0) && (addr_s != '1); // (R6)

	assign pkt_good = (sym_cnt_q == NW'(PKT)) && !frame_bad_q && (&addr_hit)
		&& addr_legal && (&data_ok); // (R5) (R11)

	// Outputs held only while packets keep arriving
	assign hold_done = (hold_q == TW'(HOLD_CYC));

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hold_q <= '0;
		else if (gap || state_q == rc_decoder_pkg::ST_IDLE || state_q == rc_decoder_pkg::ST_SLEEP)
			hold_q <= '0;
		else if (!hold_done)
			hold_q <= hold_q + TW'(1);
	end

	// Packet pairing state machine
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_q  <= rc_decoder_pkg::ST_IDLE;
			stored_q <= '0;
		end
		else if (!run)
			state_q <= rc_decoder_pkg::ST_SLEEP; // (R3)
		else
		begin
			unique case (state_q)
				rc_decoder_pkg::ST_SLEEP:
					state_q <= rc_decoder_pkg::ST_IDLE;
				rc_decoder_pkg::ST_IDLE:
					if (gap && pkt_good)
					begin
						stored_q <= data_val;
						state_q  <= rc_decoder_pkg::ST_ARMED; // (R10)
					end
				rc_decoder_pkg::ST_ARMED, rc_decoder_pkg::ST_VALID:
					if (gap && pkt_good && data_val == stored_q)
						state_q <= rc_decoder_pkg::ST_VALID; // (R10)
					else if (gap && pkt_good)
					begin
						// A toggled data line restarts the pairing
						stored_q <= data_val;
						state_q  <= rc_decoder_pkg::ST_ARMED; // (R10)
					end
					else if (gap || hold_done)
						state_q <= rc_decoder_pkg::ST_IDLE; // (R11)
			endcase
		end
	end

	// Latched outputs follow the pairing result
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			decoded_outputs_o    <= '0;
			valid_transmission_o <= 1'b0;
		end
		else if (state_q == rc_decoder_pkg::ST_VALID)
		begin
			decoded_outputs_o    <= stored_q; // (R1) (R12)
			valid_transmission_o <= 1'b1; // (R2)
		end
		else
		begin
			decoded_outputs_o    <= '0; // (R11)
			valid_transmission_o <= 1'b0; // (R11)
		end
	end

	// Events: flag edges and rejected frames
	assign ev_up     = (state_q == rc_decoder_pkg::ST_VALID) && !valid_transmission_o;
	assign ev_down   = (state_q != rc_decoder_pkg::ST_VALID) && valid_transmission_o;
	assign ev_reject = gap && !pkt_good;

	always_comb
	begin
		irq_evt                  = '0;
		irq_evt[`IRQ_VALID_UP]   = ev_up;
		irq_evt[`IRQ_VALID_DOWN] = ev_down;
		irq_evt[`IRQ_REJECT]     = ev_reject;
	end

	// APB phases; zero wait states
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;

	// Control and mask writes
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_en_q  <= `CTRL_RESET;
			irq_mask_q <= `IRQ_MASK_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == `REG_CTRL)
				ctrl_en_q <= pwdata[`CTRL_EN_BIT];
			if (paddr == `REG_IRQ_MASK)
				irq_mask_q <= pwdata[`IRQ_BITS-1:0];
		end
	end

	// Sticky status; a read clears only the bits it reported, so events after setup survive
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			irq_stat_q <= '0;
		else if (rd_en && paddr == `REG_IRQ_STATUS)
			irq_stat_q <= (irq_stat_q & ~prdata[`IRQ_BITS-1:0]) | irq_evt;
		else
			irq_stat_q <= irq_stat_q | irq_evt;
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

	// Read mux; unmapped offsets read zero and raise an error
	always_comb
	begin
		rdata  = '0;
		mapped = 1'b1;
		case (paddr)
			`REG_CTRL:       rdata[`CTRL_EN_BIT] = ctrl_en_q;
			`REG_STATUS:     rdata[DATA_W+5:0] = {state_q, !awake_s, valid_transmission_o,
				decoded_outputs_o};
			`REG_IRQ_STATUS: rdata[`IRQ_BITS-1:0] = irq_stat_q;
			`REG_IRQ_MASK:   rdata[`IRQ_BITS-1:0] = irq_mask_q;
			`REG_LAST_DATA:  rdata[DATA_W-1:0] = stored_q;
			default:         mapped = 1'b0;
		endcase
	end

	// Read data and error captured in the setup cycle, so they come from flops
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : rdata;
			pslverr <= !mapped;
		end
	end

endmodule : remote_control_packet_decoder
